// *** hdl/wtc_top.sv ***
// Summary of operation
// - Time-out in an interrupt mode sets the time-out interrupt flag.
// - Taking the interrupt vector clears the flag in hardware.
// - Writing one to the flag clears it; writing zero keeps it.
// - Interrupt requested only with global enable, irq enable and flag set.
// - Combined mode: vector taken clears irq enable and flag, leaving reset mode.
// - Combined mode: a second time-out with the flag unserviced resets.
// - Fuse off: enables decode stopped/irq/reset/both; fuse on: always reset.
// - Clearing reset enable or changing prescale needs change enable set.
// - Change enable clears itself four system clocks after being written.
// - Reset-cause flag forces reset enable set; clear cause first.
// - Prescale code selects 2048 cycles doubled per step; above 1001 reserved.
// - Counter advances on 128 kHz oscillator cycles and times out at limit.
// - Watchdog-reset instruction restarts counter; software issues it in time.
// - Fuse on holds reset enable at one and irq enable at zero.
//
// The register addresses and the Avalon-MM register port were left to the implementer.

`include "wtc_consts.svh"

module wtc_top
  import wtc_pkg::*;
#(
  parameter int OSC_DIV = `WTC_OSC_DIV,
  parameter int BASE_CYCLES = `WTC_BASE_OSC_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`WTC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  input wire logic wdr_exec,
  input wire logic always_on_fuse,
  input wire logic watchdog_reset_cause_flag,
  output logic timeout_irq_req,
  output logic system_reset_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  wtc_state_t st_reg;
  wtc_state_t st_next;
  wtc_bus_req_t req;
  wtc_csr_t wr_csr;
  wtc_csr_t csr_view;
  wtc_mode_t mode;
  logic eff_rst_en;
  logic eff_irq_en;
  logic osc_tick;
  logic tmo_pulse;
  logic run;
  logic bus_req;
  logic bus_accept;
  logic csr_write;
  logic [7:0] stat_view;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator tick and time-out counter

  wtc_tick_div #(
    .DIV(OSC_DIV)
  ) u_tick_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .osc_tick(osc_tick)
  );

  wtc_counter #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_counter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .osc_tick(osc_tick),
    .run(run),
    .restart(wdr_exec),
    .presc({st_reg.csr.presc_hi, st_reg.csr.presc_lo}),
    .timeout(tmo_pulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  // Cause flag and fuse override the stored bits on read and in action
  assign eff_rst_en = always_on_fuse | st_reg.csr.rst_en | watchdog_reset_cause_flag;
  assign eff_irq_en = ~always_on_fuse & st_reg.csr.irq_en;

  always_comb
  begin
    case ({eff_rst_en, eff_irq_en})
      2'b00: mode = WTC_STOPPED;
      2'b01: mode = WTC_IRQ_MODE;
      2'b10: mode = WTC_RST_MODE;
      2'b11: mode = WTC_IRQ_RST_MODE;
      default: mode = WTC_STOPPED;
    endcase
  end

  assign run = (mode != WTC_STOPPED);

  ////////////////////////////////////////////////////////////////////////////
  // Bus request and read views

  assign req.rd = avs_read;
  assign req.wr = avs_write;
  assign req.addr = avs_address;
  assign req.be0 = avs_byteenable[0];
  assign req.wdata = avs_writedata[7:0];

  assign bus_req = req.rd | req.wr;
  // A request is taken on the edge where waitrequest is already low
  assign bus_accept = bus_req & ~st_reg.waitreq;
  assign csr_write = bus_accept & req.wr & req.be0 & (req.addr == `WTC_CSR_ADDR);
  assign wr_csr = wtc_csr_t'(req.wdata);

  always_comb
  begin
    csr_view = st_reg.csr;
    csr_view.rst_en = eff_rst_en;
    csr_view.irq_en = eff_irq_en;
  end

  always_comb
  begin
    stat_view = 8'h00;
    stat_view[1:0] = mode;
    stat_view[`WTC_STAT_FUSE_BIT] = always_on_fuse;
    stat_view[`WTC_STAT_CAUSE_BIT] = watchdog_reset_cause_flag;
    stat_view[`WTC_STAT_CE_BIT] = st_reg.csr.change_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    st_next = st_reg;
    st_next.rst_req = 1'b0;
    // One register stage between counter and the actions it triggers
    st_next.tmo_evt = tmo_pulse;

    // Bus handshake: one wait cycle, then one cycle with waitrequest low
    if (bus_req && st_reg.waitreq)
    begin
      st_next.waitreq = 1'b0;
      case (req.addr)
        `WTC_CSR_ADDR: st_next.rdata = csr_view;
        `WTC_STAT_ADDR: st_next.rdata = stat_view;
        default: st_next.rdata = 8'h00;
      endcase
    end
    else
    begin
      st_next.waitreq = 1'b1;
    end

    // Change-enable window counts down in system clocks
    if (st_reg.csr.change_en)
    begin
      if (st_reg.ce_cnt == 2'h0)
        st_next.csr.change_en = 1'b0;
      else
        st_next.ce_cnt = st_reg.ce_cnt - 2'h1;
    end

    if (csr_write)
    begin
      if (wr_csr.flag)
        st_next.csr.flag = 1'b0;
      st_next.csr.irq_en = wr_csr.irq_en;
      st_next.csr.change_en = wr_csr.change_en;
      if (wr_csr.change_en)
        st_next.ce_cnt = 2'(`WTC_CE_CYCLES - 1);
      // Setting reset enable is always allowed; clearing is guarded
      if (wr_csr.rst_en)
        st_next.csr.rst_en = 1'b1;
      else if (st_reg.csr.change_en && !watchdog_reset_cause_flag)
        st_next.csr.rst_en = 1'b0;
      if (st_reg.csr.change_en)
      begin
        st_next.csr.presc_hi = wr_csr.presc_hi;
        st_next.csr.presc_lo = wr_csr.presc_lo;
      end
    end

    if (irq_vector_taken)
    begin
      st_next.csr.flag = 1'b0;
      if (mode == WTC_IRQ_RST_MODE)
        st_next.csr.irq_en = 1'b0;
    end

    // Placed after the clears so a time-out wins over a clear in the same cycle
    if (st_reg.tmo_evt)
    begin
      case (mode)
        WTC_IRQ_MODE: st_next.csr.flag = 1'b1;
        WTC_RST_MODE: st_next.rst_req = 1'b1;
        WTC_IRQ_RST_MODE:
        begin
          if (st_reg.csr.flag)
            st_next.rst_req = 1'b1;
          else
            st_next.csr.flag = 1'b1;
        end
        default: st_next.rst_req = 1'b0;
      endcase
    end

    if (always_on_fuse)
    begin
      st_next.csr.irq_en = 1'b0;
      st_next.csr.rst_en = 1'b1;
    end

    st_next.irq_req = global_irq_enable & eff_irq_en & st_reg.csr.flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.csr <= `WTC_CSR_RESET;
      st_reg.waitreq <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata = {24'h000000, st_reg.rdata};
  assign avs_waitrequest = st_reg.waitreq;
  assign timeout_irq_req = st_reg.irq_req;
  assign system_reset_req = st_reg.rst_req;

endmodule

// *** hdl/wtc_consts.svh ***
`ifndef WTC_CONSTS_SVH
`define WTC_CONSTS_SVH

// System clock and the watchdog oscillator, each in its own unit
`define WTC_CLK_MHZ 125
`define WTC_OSC_KHZ 128
// Oscillator period in system clocks, rounded down (976)
`define WTC_OSC_DIV ((`WTC_CLK_MHZ * 1000) / `WTC_OSC_KHZ)

// Shortest time-out in oscillator cycles, doubled per prescale code
`define WTC_BASE_OSC_CYCLES 2048
`define WTC_PRESC_MAX 4'h9
`define WTC_CNT_W 21

// Change-enable window in system clock cycles
`define WTC_CE_CYCLES 4

// Register map, Avalon word addresses
`define WTC_ADDR_W 2
`define WTC_CSR_ADDR 2'h0
`define WTC_STAT_ADDR 2'h1
`define WTC_CSR_RESET 8'h00
`define WTC_STAT_FUSE_BIT 2
`define WTC_STAT_CAUSE_BIT 3
`define WTC_STAT_CE_BIT 4

`endif

// *** hdl/wtc_pkg.sv ***
package wtc_pkg;

  // Control/status byte, msb first as it sits on the bus
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic presc_hi;
    logic change_en;
    logic rst_en;
    logic [2:0] presc_lo;
  } wtc_csr_t;

  typedef enum logic [1:0] {
    WTC_STOPPED,
    WTC_IRQ_MODE,
    WTC_RST_MODE,
    WTC_IRQ_RST_MODE
  } wtc_mode_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] addr;
    logic be0;
    logic [7:0] wdata;
  } wtc_bus_req_t;

  typedef struct packed {
    wtc_csr_t csr;
    logic [1:0] ce_cnt;
    logic tmo_evt;
    logic irq_req;
    logic rst_req;
    logic waitreq;
    logic [7:0] rdata;
  } wtc_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } wtc_div_state_t;

  typedef struct packed {
    logic [20:0] cnt;
    logic timeout;
  } wtc_cnt_state_t;

endpackage

// *** hdl/wtc_tick_div.sv ***
`include "wtc_consts.svh"

// Stands in for the free-running watchdog oscillator: one tick per oscillator period
module wtc_tick_div
  import wtc_pkg::*;
#(
  parameter int DIV = `WTC_OSC_DIV
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic osc_tick
);

  wtc_div_state_t st_reg;
  wtc_div_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt >= 16'(DIV - 1))
    begin
      st_next.cnt = 16'h0000;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign osc_tick = st_reg.tick;

endmodule

// *** hdl/wtc_counter.sv ***
`include "wtc_consts.svh"

module wtc_counter
  import wtc_pkg::*;
#(
  parameter int BASE_CYCLES = `WTC_BASE_OSC_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic osc_tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [3:0] presc,
  output logic timeout
);

  wtc_cnt_state_t st_reg;
  wtc_cnt_state_t st_next;
  logic [3:0] sel;
  logic [`WTC_CNT_W-1:0] limit;

  // Reserved codes behave as the longest period
  assign sel = (presc > `WTC_PRESC_MAX) ? `WTC_PRESC_MAX : presc;
  assign limit = `WTC_CNT_W'(BASE_CYCLES) << sel;

  always_comb
  begin
    st_next = st_reg;
    st_next.timeout = 1'b0;
    if (!run || restart)
    begin
      st_next.cnt = '0;
    end
    else if (osc_tick)
    begin
      // Compare with >= so a shorter period set mid-count expires on the next oscillator tick
      if (st_reg.cnt >= limit - `WTC_CNT_W'(1))
      begin
        st_next.cnt = '0;
        st_next.timeout = 1'b1;
      end
      else
      begin
        st_next.cnt = st_reg.cnt + `WTC_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign timeout = st_reg.timeout;

endmodule

// *** bench/wtc_top_monitor.sv ***
`include "wtc_consts.svh"

module wtc_top_monitor
  import wtc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`WTC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  input wire logic wdr_exec,
  input wire logic always_on_fuse,
  input wire logic watchdog_reset_cause_flag,
  input wire logic timeout_irq_req,
  input wire logic system_reset_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  a_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("waitrequest not dropped after request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_irq_gie_past: assert property (timeout_irq_req |-> $past(global_irq_enable))
    else $error("irq request without global enable");
  a_irq_gie_fell: assert property ($fell(global_irq_enable) |=> !timeout_irq_req)
    else $error("irq request kept after global enable fell");
  // Three cycles of fuse history cover the registered lag of the request
  a_fuse_no_irq: assert property (always_on_fuse && $past(always_on_fuse) &&
    $past(always_on_fuse, 2) && $past(always_on_fuse, 3) |-> !timeout_irq_req)
    else $error("irq request while fuse programmed");
  a_reset_pulse: assert property (system_reset_req |=> !system_reset_req)
    else $error("reset request longer than one cycle");
  a_vector_clear: assert property (irq_vector_taken |-> ##2 !timeout_irq_req)
    else $error("irq request not cleared by vector");
  c_reset: cover property (system_reset_req);
  c_vector: cover property (timeout_irq_req && irq_vector_taken);
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule

bind wtc_top wtc_top_monitor wtc_top_monitor_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken),
  .wdr_exec(wdr_exec), .always_on_fuse(always_on_fuse),
  .watchdog_reset_cause_flag(watchdog_reset_cause_flag),
  .timeout_irq_req(timeout_irq_req), .system_reset_req(system_reset_req)
);

// *** bench/wtc_top_tb_top.sv ***
module wtc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short tick and base count keep the longest period near 8k cycles
  localparam int DIV = 4;
  localparam int BASE = 4;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [1:0] addr = 2'h0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic gie = 1'h0, vec = 1'h0, wdr = 1'h0, fuse = 1'h0, cause = 1'h0;
  logic [31:0] rdata;
  logic waitreq, irq, rreq;
  int errors = 0, checks_done = 0, cyc = 0;

  always #4 ref_clk = ~ref_clk;

  wtc_top #(.OSC_DIV(DIV), .BASE_CYCLES(BASE)) wtc_top_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .global_irq_enable(gie), .irq_vector_taken(vec),
    .wdr_exec(wdr), .always_on_fuse(fuse), .watchdog_reset_cause_flag(cause),
    .timeout_irq_req(irq), .system_reset_req(rreq)
  );
  //////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held until the edge that samples waitrequest low
  task bus(input logic w, input logic [1:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    addr <= a;
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do @(posedge ref_clk); while (waitreq !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask

  task put(input logic [1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask

  task get(input string nm, input logic [1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 8'h00, q);
    check(nm, q, exp);
  endtask

  task pulse(input logic w);
    @(posedge ref_clk);
    if (w)
      wdr <= 1'h1;
    else
      vec <= 1'h1;
    @(posedge ref_clk);
    wdr <= 1'h0;
    vec <= 1'h0;
  endtask

  task evt(input string nm, input logic w, output int n);
    n = 0;
    while ((w ? rreq : irq) !== 1'h1 && n < 20000)
    begin
      @(posedge ref_clk);
      n++;
    end
    check(nm, {31'h0, w ? rreq : irq}, 32'h1);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task t_reset;
    be <= 4'h0;
    put(2'h0, 8'h40);
    be <= 4'hF;
    get("csr", 2'h0, 32'h00);
    get("status", 2'h1, 32'h00);
    put(2'h2, 8'hFF);
    get("unmapped", 2'h2, 32'h00);
    $display("reset test done");
  endtask

  task t_irq;
    int n;
    put(2'h0, 8'h18);
    put(2'h0, 8'h02);
    gie <= 1'h1;
    put(2'h0, 8'h42);
    get("irq mode", 2'h1, 32'h01);
    evt("irq", 1'h0, n);
    get("flag set", 2'h0, 32'hC2);
    gie <= 1'h0;
    repeat (2) @(posedge ref_clk);
    check("gie off", {31'h0, irq}, 32'h0);
    gie <= 1'h1;
    put(2'h0, 8'h42);
    get("zero keeps", 2'h0, 32'hC2);
    put(2'h0, 8'hC2);
    get("one clears", 2'h0, 32'h42);
    evt("irq again", 1'h0, n);
    pulse(1'h0);
    get("vector", 2'h0, 32'h42);
    $display("irq test done");
  endtask

  task t_comb;
    int n;
    put(2'h0, 8'h4A);
    get("comb mode", 2'h1, 32'h03);
    evt("comb irq", 1'h0, n);
    evt("comb reset", 1'h1, n);
    pulse(1'h0);
    get("comb vector", 2'h0, 32'h0A);
    get("reset mode", 2'h1, 32'h02);
    // Re-armed outside the handler, then dropped so later tests start in reset mode
    put(2'h0, 8'h4A);
    get("re-armed", 2'h1, 32'h03);
    put(2'h0, 8'h0A);
    $display("combined test done");
  endtask

  task t_ce;
    put(2'h0, 8'h02);
    get("clear refused", 2'h0, 32'h0A);
    put(2'h0, 8'h0B);
    get("presc refused", 2'h0, 32'h0A);
    put(2'h0, 8'h1A);
    get("ce set", 2'h1, 32'h12);
    repeat (4) @(posedge ref_clk);
    get("ce gone", 2'h1, 32'h02);
    put(2'h0, 8'h00);
    get("late clear", 2'h0, 32'h0A);
    put(2'h0, 8'h1A);
    put(2'h0, 8'h00);
    get("timed clear", 2'h0, 32'h00);
    $display("change enable test done");
  endtask

  task t_cause;
    cause <= 1'h1;
    get("cause csr", 2'h0, 32'h08);
    get("cause status", 2'h1, 32'h0A);
    put(2'h0, 8'h18);
    put(2'h0, 8'h00);
    cause <= 1'h0;
    get("cause kept", 2'h0, 32'h08);
    put(2'h0, 8'h18);
    put(2'h0, 8'h00);
    get("cause cleared", 2'h0, 32'h00);
    $display("cause test done");
  endtask

  task t_fuse;
    int n;
    fuse <= 1'h1;
    put(2'h0, 8'h40);
    get("fuse csr", 2'h0, 32'h08);
    get("fuse status", 2'h1, 32'h06);
    evt("fuse reset", 1'h1, n);
    fuse <= 1'h0;
    put(2'h0, 8'h18);
    put(2'h0, 8'h00);
    $display("fuse test done");
  endtask

  // Kicks every 8 cycles keep a 16-cycle period from ever expiring
  task t_kick;
    int n;
    int seen;
    seen = 0;
    put(2'h0, 8'h18);
    put(2'h0, 8'h08);
    for (int i = 0; i < 64; i++)
    begin
      @(posedge ref_clk);
      if (rreq === 1'h1)
        seen++;
      wdr <= (i % 8 == 0);
    end
    check("kicked", seen, 32'h0);
    evt("unkicked", 1'h1, n);
    put(2'h0, 8'h18);
    put(2'h0, 8'h00);
    $display("kick test done");
  endtask

  // A reset in mid-run must return every output and the register to idle
  task t_restart;
    put(2'h0, 8'h48);
    get("armed", 2'h1, 32'h03);
    @(posedge ref_clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    check("reset waitrequest", {31'h0, waitreq}, 32'h1);
    check("reset readdata", rdata, 32'h0);
    check("reset irq", {31'h0, irq}, 32'h0);
    check("reset request", {31'h0, rreq}, 32'h0);
    rst_n <= 1'h1;
    get("csr after reset", 2'h0, 32'h00);
    get("status after reset", 2'h1, 32'h00);
    $display("restart test done");
  endtask

  // Code 12 is reserved and must fall back to the longest period
  task t_period;
    int n;
    int p;
    logic [3:0] c;
    int codes[4];
    codes = '{0, 3, 9, 12};
    for (int i = 0; i < 4; i++)
    begin
      c = codes[i];
      pulse(1'h1);
      put(2'h0, 8'h18);
      put(2'h0, {2'h0, c[3], 2'h1, c[2:0]});
      pulse(1'h1);
      evt("period", 1'h1, n);
      p = BASE * DIV << (c > 9 ? 9 : c);
      check("period len", {31'h0, n >= p - DIV && n <= p + DIV + 4}, 32'h1);
    end
    put(2'h0, 8'h18);
    put(2'h0, 8'h00);
    $display("period test done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      end_of_test;
    end
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_reset;
    t_irq;
    t_comb;
    t_ce;
    t_cause;
    t_fuse;
    t_kick;
    t_restart;
    t_period;
    end_of_test;
  end
endmodule
